// >>> design/contact_scan_pkg.sv
// constants shared by the isolated contact input scanner
// assumes a 20 MHz pclk and an APB master with 32-bit data
package contact_scan_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned SCAN_PERIOD_US  = 1000;
   localparam int unsigned SCAN_CYC        = CLK_HZ / 1_000_000 * SCAN_PERIOD_US;
   localparam int unsigned FRAME_BASE_MS   = 10;
   localparam int unsigned NCH             = 16;
   // apb byte offsets
   localparam logic [7:0] ADR_CTRL     = 8'h00;
   localparam logic [7:0] ADR_USED     = 8'h04;
   localparam logic [7:0] ADR_INVERT   = 8'h08;
   localparam logic [7:0] ADR_ISOLATE  = 8'h0c;
   localparam logic [7:0] ADR_LEVEL0   = 8'h10;
   localparam logic [7:0] ADR_LEVEL1   = 8'h14;
   localparam logic [7:0] ADR_FILTER0  = 8'h18;
   localparam logic [7:0] ADR_FILTER1  = 8'h1c;
   localparam logic [7:0] ADR_STATE    = 8'h20;
   localparam logic [7:0] ADR_WET_OK   = 8'h24;
   localparam logic [7:0] ADR_OPEN     = 8'h28;
   localparam logic [7:0] ADR_SHORT    = 8'h2c;
   localparam logic [7:0] ADR_EVENT    = 8'h30;
   localparam logic [7:0] ADR_STAMP    = 8'h34;
   localparam logic [7:0] ADR_IDENT    = 8'h38;
   localparam logic [7:0] ADR_EXP_TB   = 8'h3c;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h40;
   localparam logic [7:0] ADR_IRQ_CLR  = 8'h44;
   localparam logic [7:0] ADR_IRQ_EN   = 8'h48;
   // control and event register fields
   localparam int CTRL_FRAME_LSB = 0;
   localparam int CTRL_SOE_BIT   = 3;
   localparam int CTRL_LMON_LSB  = 4;
   localparam int EVT_VALID_BIT  = 31;
   localparam int EVT_STATE_BIT  = 4;
   // interrupt status bits
   localparam int IRQ_EVENT  = 0;
   localparam int IRQ_WET    = 1;
   localparam int IRQ_LINE   = 2;
   localparam int IRQ_EXC    = 3;
   localparam int IRQ_TB     = 4;
   localparam int IRQ_OVF    = 5;
   localparam int IRQ_W      = 6;
   localparam logic [2:0] FRAME_SEL_MAX = 3'h5;
   typedef enum logic [1:0] {LMON_NONE = 2'b00, LMON_SINGLE = 2'b01,
                             LMON_DUAL = 2'b10} lmon_t;
   typedef enum logic [1:0] {WB_NONE = 2'b00, WB_LOW = 2'b01,
                             WB_MID = 2'b10, WB_125 = 2'b11} wboard_t;
   // debounce selections in milliseconds
   localparam logic [6:0] FILT_MS [5] = '{7'd0, 7'd10, 7'd20, 7'd50, 7'd100};
   // wetting ranges in volts: 24dc 48dc 125dc 250dc 115ac 230ac
   localparam int NLEVEL = 6;
   localparam logic [8:0] WET_LO [NLEVEL] = '{9'd14, 9'd19, 9'd50, 9'd100, 9'd90, 9'd90};
   localparam logic [8:0] WET_HI [NLEVEL] = '{9'd32, 9'd64, 9'd156, 9'd264, 9'd143, 9'd264};
endpackage

// >>> design/contact_scanner.sv
// contact input scanning, wetting checks, line faults, leds and events
// assumes voltage readings and apb come from same-clock logic, all else from pins
// Behaviour
// - take sixteen contact inputs and pass each state on for reporting
// - flag invalid voltage when a reading leaves its configured nominal range
// - report a channel as false while its wetting voltage is invalid
// - judge wetting validity only while voltage is present at the terminals
// - range comparison is exact, well inside six percent of reading
// - latch reports each frame of 10, 20, 40, 80, 160 or 320 ms
// - sample contacts on a separate one kilohertz scan tick
// - with recording on, stamp transitions to the millisecond scan tick
// - led green when true, dark when false or unused, red on faults
// - detect lost excitation, lost system wetting and a wrong terminal board
// - single-resistor monitoring reports blown fuse or open wire on any board
// - dual-resistor monitoring also reports line shorts on supporting boards
// - run on either net port, primary preferred, redundant as fallback
// - show acquisition board identity and pass terminal board identity through
// - with the 125 V board all channels are system wetted, isolation ignored
// - per-channel debounce: none, 10, 20, 50 or 100 ms
// - per-channel inversion makes an open contact read true
//
// Our own choices: the register addresses and register access over APB.
module contact_scanner
   import contact_scan_pkg::*;
#(
   parameter int unsigned SCAN_CYCLES = SCAN_CYC,
   parameter logic [7:0]  ACQ_ID      = 8'h5a // arbitrary identity value
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] contact_in,
   input  wire logic [15:0] wet_present,
   input  wire logic [15:0] line_open_in,
   input  wire logic [15:0] line_short_in,
   input  wire logic        sys_wet_present,
   input  wire logic [1:0]  wet_board_type,
   input  wire logic [7:0]  tb_id_in,
   input  wire logic        primary_link_up,
   input  wire logic        redundant_link_up,
   input  wire logic        meas_valid,
   input  wire logic [3:0]  meas_chan,
   input  wire logic [8:0]  meas_volt,
   output logic [15:0]      contact_state,
   output logic [15:0]      led_green,
   output logic [15:0]      led_red,
   output logic             net_port_sel,
   output logic             irq
);
   localparam int SW = 77; // synchronised pin bits
   logic [SW-1:0] sync1_q, sync2_q;
   logic [15:0] con_s, pres_s, open_s, short_s;
   logic        sysw_s, prim_s, red_s;
   logic [1:0]  board_s;
   logic [7:0]  tbid_s;
   logic [2:0]  frame_sel_q;
   logic        soe_en_q;
   logic [1:0]  lmon_q;
   logic [15:0] used_q, invert_q, iso_q, iso_eff;
   logic [63:0] level_q, filter_q;
   logic [15:0] filt, eff;
   logic [15:0] wet_bad_q, exc_lost, open_q, short_q, state_q, wet_ok_q;
   logic [15:0] prev_q, chg, pend_q;
   logic [31:0] stamp_q [NCH];
   logic [31:0] ms_count_q, evt_stamp_q;
   logic [14:0] scan_cnt_q;
   logic        scan_tick;
   logic [8:0]  frame_cnt_q;
   logic        frame_tick;
   logic        evt_valid_q, evt_state_q, pop, evt_read;
   logic [3:0]  evt_chan_q, pop_idx;
   logic [7:0]  exp_tb_q;
   logic [IRQ_W-1:0] irq_stat_q, irq_en_q, irq_set;
   logic        wr, rd, hit;
   logic        tb_bad, sys_lost;

   // two-stage synchroniser for every pin input
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {contact_in, wet_present, line_open_in, line_short_in,
                     sys_wet_present, wet_board_type, tb_id_in,
                     primary_link_up, redundant_link_up};
         sync2_q <= sync1_q;
      end
   end
   assign {con_s, pres_s, open_s, short_s, sysw_s, board_s, tbid_s,
           prim_s, red_s} = sync2_q;

   // apb: zero wait states, error on unmapped offsets
   assign pready = 1'b1;
   assign wr     = psel && penable && pwrite;
   assign rd     = psel && penable && !pwrite;
   always_comb
   begin
      hit = 1'b1;
      prdata = 32'h0000_0000;
      case (paddr)
         ADR_CTRL:     prdata = {26'h0, lmon_q, soe_en_q, frame_sel_q};
         ADR_USED:     prdata = {16'h0, used_q};
         ADR_INVERT:   prdata = {16'h0, invert_q};
         ADR_ISOLATE:  prdata = {16'h0, iso_eff};
         ADR_LEVEL0:   prdata = level_q[31:0];
         ADR_LEVEL1:   prdata = level_q[63:32];
         ADR_FILTER0:  prdata = filter_q[31:0];
         ADR_FILTER1:  prdata = filter_q[63:32];
         ADR_STATE:    prdata = {16'h0, state_q};
         ADR_WET_OK:   prdata = {16'h0, wet_ok_q};
         ADR_OPEN:     prdata = {16'h0, open_q};
         ADR_SHORT:    prdata = {16'h0, short_q};
         ADR_EVENT:    prdata = {evt_valid_q, 26'h0, evt_state_q, evt_chan_q};
         ADR_STAMP:    prdata = evt_stamp_q;
         ADR_IDENT:    prdata = {13'h0, net_port_sel, board_s, tbid_s, ACQ_ID};
         ADR_EXP_TB:   prdata = {24'h0, exp_tb_q};
         ADR_IRQ_STAT: prdata = {26'h0, irq_stat_q};
         ADR_IRQ_CLR:  prdata = 32'h0000_0000;
         ADR_IRQ_EN:   prdata = {26'h0, irq_en_q};
         default:      hit = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !hit;

   // software configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frame_sel_q <= 3'h0;
         soe_en_q    <= 1'b0;
         lmon_q      <= LMON_NONE;
         used_q      <= 16'h0000;
         invert_q    <= 16'h0000;
         iso_q       <= 16'h0000;
         level_q     <= 64'h0;
         filter_q    <= 64'h0;
         exp_tb_q    <= 8'h00;
         irq_en_q    <= '0;
      end
      else if (wr)
      begin
         case (paddr)
            ADR_CTRL:
            begin
               if (pwdata[CTRL_FRAME_LSB +: 3] <= FRAME_SEL_MAX)
                  frame_sel_q <= pwdata[CTRL_FRAME_LSB +: 3];
               soe_en_q <= pwdata[CTRL_SOE_BIT];
               lmon_q   <= pwdata[CTRL_LMON_LSB +: 2];
            end
            ADR_USED:    used_q   <= pwdata[15:0];
            ADR_INVERT:  invert_q <= pwdata[15:0];
            ADR_ISOLATE:
            begin
               if (board_s != WB_125)
                  iso_q <= pwdata[15:0];
            end
            ADR_LEVEL0:  level_q[31:0]   <= pwdata;
            ADR_LEVEL1:  level_q[63:32]  <= pwdata;
            ADR_FILTER0: filter_q[31:0]  <= pwdata;
            ADR_FILTER1: filter_q[63:32] <= pwdata;
            ADR_EXP_TB:  exp_tb_q <= pwdata[7:0];
            ADR_IRQ_EN:  irq_en_q <= pwdata[IRQ_W-1:0];
            default:     ;
         endcase
      end
   end

   // isolation in force: bare terminal board checks all, 125 V board none
   assign iso_eff = (board_s == WB_NONE) ? 16'hffff :
                    (board_s == WB_125) ? 16'h0000 : iso_q;

   // one kilohertz scan tick and millisecond time base
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scan_cnt_q <= 15'h0000;
         ms_count_q <= 32'h0000_0000;
      end
      else if (scan_tick)
      begin
         scan_cnt_q <= 15'h0000;
         ms_count_q <= ms_count_q + 32'h1;
      end
      else
         scan_cnt_q <= scan_cnt_q + 15'h0001;
   end
   assign scan_tick = (scan_cnt_q == 15'(SCAN_CYCLES - 1));

   // control frame: base period in scan ticks, doubled per selection step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         frame_cnt_q <= 9'h000;
      else if (frame_tick)
         frame_cnt_q <= 9'h000;
      else if (scan_tick)
         frame_cnt_q <= frame_cnt_q + 9'h001;
   end
   assign frame_tick = scan_tick &&
      (frame_cnt_q == 9'((FRAME_BASE_MS << frame_sel_q) - 1));

   // per-channel debounce, then polarity
   for (genvar i = 0; i < NCH; i++)
   begin : g_ch
      debounce_chan u_deb (
         .pclk      (pclk),
         .presetn   (presetn),
         .scan_tick (scan_tick),
         .raw       (con_s[i]),
         .sel       (filter_q[4*i +: 4]),
         .filt      (filt[i])
      );
   end
   assign eff = filt ^ invert_q;

   // wetting check on each reading, only where voltage is present
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wet_bad_q <= 16'h0000;
      else
      begin
         wet_bad_q <= wet_bad_q & used_q & iso_eff & pres_s;
         if (meas_valid)
         begin
            if (!(used_q[meas_chan] && iso_eff[meas_chan] && pres_s[meas_chan]))
               wet_bad_q[meas_chan] <= 1'b0;
            else if (level_q[4*meas_chan +: 4] >= 4'(NLEVEL))
               wet_bad_q[meas_chan] <= 1'b1;
            else
               wet_bad_q[meas_chan] <=
                  (meas_volt < WET_LO[level_q[4*meas_chan +: 3]]) ||
                  (meas_volt > WET_HI[level_q[4*meas_chan +: 3]]);
         end
      end
   end

   // excitation, system wetting and terminal board checks
   assign exc_lost = used_q & iso_eff & ~pres_s;
   assign sys_lost = (board_s != WB_NONE) && !sysw_s && |(used_q & ~iso_eff);
   assign tb_bad   = (tbid_s != exp_tb_q);

   // field line monitoring, short only on boards with dual resistors
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         open_q  <= 16'h0000;
         short_q <= 16'h0000;
      end
      else
      begin
         open_q  <= (lmon_q != LMON_NONE) ? (open_s & used_q) : 16'h0000;
         short_q <= (lmon_q == LMON_DUAL && (board_s == WB_MID || board_s == WB_125))
                    ? (short_s & used_q) : 16'h0000;
      end
   end

   // frame report latch; invalid channels report false
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q  <= 16'h0000;
         wet_ok_q <= 16'hffff;
      end
      else if (frame_tick)
      begin
         state_q  <= eff & used_q & ~wet_bad_q & ~exc_lost;
         wet_ok_q <= ~(wet_bad_q | exc_lost);
      end
   end
   assign contact_state = state_q;

   // indicators and network port choice
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         led_green    <= 16'h0000;
         led_red      <= 16'h0000;
         net_port_sel <= 1'b0;
      end
      else
      begin
         led_red   <= used_q & (wet_bad_q | exc_lost | open_q | short_q);
         led_green <= used_q & eff & ~(wet_bad_q | exc_lost | open_q | short_q);
         net_port_sel <= !prim_s && red_s;
      end
   end

   // transitions seen at a scan tick, with the tick count as stamp
   assign chg = (scan_tick && soe_en_q) ? ((filt ^ prev_q) & used_q & ~wet_bad_q) : 16'h0000;
   always_comb
   begin
      pop_idx = 4'h0;
      for (int k = NCH - 1; k >= 0; k--)
         if (pend_q[k])
            pop_idx = 4'(k);
   end
   assign pop      = !evt_valid_q && (pend_q != 16'h0000);
   assign evt_read = rd && (paddr == ADR_STAMP);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_q <= 16'h0000;
         pend_q <= 16'h0000;
      end
      else
      begin
         if (scan_tick)
            prev_q <= filt;
         // a new change on the popped channel wins over its clear
         pend_q <= (pend_q & ~(pop ? (16'h0001 << pop_idx) : 16'h0000)) | chg;
      end
   end

   always_ff @(posedge pclk)
   begin
      for (int k = 0; k < NCH; k++)
         if (chg[k])
            stamp_q[k] <= ms_count_q;
   end

   // event record register, freed by reading the stamp
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         evt_valid_q <= 1'b0;
         evt_state_q <= 1'b0;
         evt_chan_q  <= 4'h0;
         evt_stamp_q <= 32'h0000_0000;
      end
      else if (pop)
      begin
         evt_valid_q <= 1'b1;
         evt_chan_q  <= pop_idx;
         evt_state_q <= eff[pop_idx] ^ (filt[pop_idx] ^ prev_q[pop_idx]);
         evt_stamp_q <= stamp_q[pop_idx];
      end
      else if (evt_read)
         evt_valid_q <= 1'b0;
   end

   // sticky interrupt status; a set in the clear cycle survives
   assign irq_set[IRQ_EVENT] = pop;
   assign irq_set[IRQ_WET]   = |wet_bad_q;
   assign irq_set[IRQ_LINE]  = |(open_q | short_q);
   assign irq_set[IRQ_EXC]   = |exc_lost || sys_lost;
   assign irq_set[IRQ_TB]    = tb_bad;
   assign irq_set[IRQ_OVF]   = |(chg & pend_q);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat_q <= '0;
      else if (wr && paddr == ADR_IRQ_CLR)
         irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_set;
      else
         irq_stat_q <= irq_stat_q | irq_set;
   end
   assign irq = |(irq_stat_q & irq_en_q);

   // checks
   a_led_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
      (led_green & led_red) == 16'h0000)
      else $error("led both green and red");
   a_report_withheld: assert property (@(posedge pclk) disable iff (!presetn)
      frame_tick |=> (state_q & $past(wet_bad_q)) == 16'h0000)
      else $error("invalid channel reported");
   a_scan_spacing: assert property (@(posedge pclk) disable iff (!presetn)
      scan_tick |=> scan_cnt_q == 15'h0000 && ms_count_q == $past(ms_count_q) + 32'h1)
      else $error("scan tick off period");
   a_absent_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (meas_valid && !pres_s[meas_chan]) |=> !wet_bad_q[$past(meas_chan)])
      else $error("absent voltage judged");
   a_range_low: assert property (@(posedge pclk) disable iff (!presetn)
      (meas_valid && used_q[meas_chan] && iso_eff[meas_chan] && pres_s[meas_chan]
       && level_q[4*meas_chan +: 4] < 4'(NLEVEL)
       && meas_volt < WET_LO[level_q[4*meas_chan +: 3]])
      |=> wet_bad_q[$past(meas_chan)])
      else $error("low voltage not flagged");
   sequence s_pop;
      pop ##1 evt_valid_q;
   endsequence
   a_event_capture: assert property (@(posedge pclk) disable iff (!presetn)
      pop |-> s_pop ##0 evt_chan_q == $past(pop_idx))
      else $error("event not captured");
   a_short_gate: assert property (@(posedge pclk) disable iff (!presetn)
      lmon_q != LMON_DUAL ##1 lmon_q != LMON_DUAL |-> short_q == 16'h0000)
      else $error("short without dual mode");
   a_iso_forced: assert property (@(posedge pclk) disable iff (!presetn)
      (board_s == WB_125 && wr && paddr == ADR_ISOLATE) |=> $stable(iso_q))
      else $error("isolation written on 125 V board");
   a_net_primary: assert property (@(posedge pclk) disable iff (!presetn)
      prim_s |=> !net_port_sel)
      else $error("redundant port used with primary up");
   a_frame_latch: assert property (@(posedge pclk) disable iff (!presetn)
      !frame_tick |=> $stable(state_q))
      else $error("report changed between frames");
endmodule

// >>> design/debounce_chan.sv
// one channel of contact debounce, counted in scan ticks
// assumes raw is already synchronised to pclk
module debounce_chan
   import contact_scan_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       scan_tick,
   input  wire logic       raw,
   input  wire logic [3:0] sel,
   output logic            filt
);
   logic [6:0] cnt_q;
   logic [6:0] limit;

   // out-of-range selections act as unfiltered
   assign limit = (sel < 4'd5) ? FILT_MS[sel[2:0]] : FILT_MS[0];

   // output follows raw only after it held steady for the chosen time
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 7'h00;
         filt  <= 1'b0;
      end
      else if (raw == filt)
         cnt_q <= 7'h00;
      else if (limit == 7'h00)
         filt <= raw;
      else if (scan_tick)
      begin
         if (cnt_q + 7'h01 >= limit)
         begin
            filt  <= raw;
            cnt_q <= 7'h00;
         end
         else
            cnt_q <= cnt_q + 7'h01;
      end
   end
endmodule

// >>> tb/field_model.sv
// field side model: wetting voltage readings for each channel
// assumes pclk is shared with the scanner and the bench sets the volts
module field_model
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [15:0]      wet_present,
   input  wire logic [15:0][8:0] volts,
   output logic                  meas_valid,
   output logic [3:0]            meas_chan,
   output logic [8:0]            meas_volt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] gap_q;
   // one reading every fourth cycle; an absent supply reads as 0 V
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_q      <= 2'h0;
         meas_valid <= 1'b0;
         meas_chan  <= 4'h0;
         meas_volt  <= 9'h000;
      end
      else if (gap_q == 2'h3)
      begin
         gap_q      <= 2'h0;
         meas_valid <= 1'b1;
         meas_chan  <= meas_chan + 4'h1;
         meas_volt  <= wet_present[meas_chan + 4'h1] ? volts[meas_chan + 4'h1] : 9'h000;
      end
      else
      begin
         gap_q      <= gap_q + 2'h1;
         meas_valid <= 1'b0;
         meas_volt  <= ~meas_volt; // stale value inverted on each of the three idle cycles
      end
   end
endmodule

// >>> tb/tb_top.sv
// bench for the contact scanner: apb tasks and call sequences
// assumes a 20 MHz pclk and a scan tick shortened to 20 cycles
module tb_top
   import contact_scan_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             pclk, presetn, psel, penable, pwrite, err;
   logic [7:0]       paddr, tb_id_in;
   logic [31:0]      pwdata, prdata, rd, s1;
   logic             pready, pslverr, sys_wet_present, meas_valid;
   logic             primary_link_up, redundant_link_up, net_port_sel, irq;
   logic [15:0]      contact_in, wet_present, line_open_in, line_short_in;
   logic [15:0]      contact_state, led_green, led_red;
   logic [1:0]       wet_board_type;
   logic [3:0]       meas_chan;
   logic [8:0]       meas_volt;
   logic [15:0][8:0] volts;
   int               fails, num_checks, cyc, n;
   contact_scanner #(.SCAN_CYCLES(20), .ACQ_ID(8'h5a)) contact_scanner_i (.*);
   field_model field_model_i (.*);
   // free running clock
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // cut a hang short
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         $display("[ERR] %0t timeout", $time);
         wrap_up();
      end
   end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {contact_in, line_open_in, line_short_in, wet_board_type} = '0;
      wet_present = 16'hffff;
      sys_wet_present = 1'b1;
      tb_id_in = 8'h3c;
      primary_link_up = 1'b1;
      redundant_link_up = 1'b1;
      for (int i = 0; i < 16; i++)
         volts[i] = 9'd24;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk({16'h0, contact_state}, 32'h0);
      rdchk(ADR_WET_OK, 32'h0000_ffff);
      apb(1'b1, ADR_USED, 32'h0000_00ff);
      apb(1'b1, ADR_INVERT, 32'h0000_000f);
      contact_in <= 16'ha5a5;
      wt(500);
      chk({led_green, led_red}, 32'h00aa_0000);
      apb(1'b1, ADR_USED, 32'h0000_ffff);
      wt(500);
      rdchk(ADR_STATE, 32'h0000_a5aa);
      chk({16'h0, contact_state}, 32'h0000_a5aa);
      volts[3] <= 9'd33;
      volts[4] <= 9'd14;
      volts[5] <= 9'd13;
      volts[6] <= 9'd32;
      volts[9] <= 9'd300;
      wet_present[9] <= 1'b0;
      wet_present[8] <= 1'b0;
      wt(500);
      rdchk(ADR_WET_OK, 32'h0000_fcd7);
      rdchk(ADR_STATE, 32'h0000_a482);
      chk({led_green, led_red}, 32'ha482_0328);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, ADR_IRQ_STAT, 32'h0);
      chk(rd & 32'h0000_001a, 32'h0000_001a);
      apb(1'b1, ADR_IRQ_EN, 32'h0000_0002);
      apb(1'b1, ADR_IRQ_CLR, 32'h0000_0002);
      wt(2);
      chk({31'h0, irq}, 32'h1);
      for (int i = 3; i < 10; i++)
         volts[i] <= 9'd24;
      wet_present <= 16'hffff;
      wt(500);
      apb(1'b1, ADR_IRQ_CLR, 32'h0000_003f);
      wt(2);
      chk({31'h0, irq}, 32'h0);
      rdchk(ADR_WET_OK, 32'h0000_ffff);
      apb(1'b1, ADR_CTRL, 32'h0000_0010);
      line_open_in <= 16'h0080;
      line_short_in <= 16'h0400;
      wt(500);
      rdchk(ADR_OPEN, 32'h0000_0080);
      rdchk(ADR_SHORT, 32'h0000_0000);
      chk({16'h0, led_red}, 32'h0000_0080);
      wet_board_type <= 2'h2;
      apb(1'b1, ADR_CTRL, 32'h0000_0020);
      wt(500);
      rdchk(ADR_SHORT, 32'h0000_0400);
      {line_open_in, line_short_in, wet_board_type} <= '0;
      apb(1'b1, ADR_CTRL, 32'h0000_0008);
      wt(500);
      apb(1'b1, ADR_IRQ_CLR, 32'h0000_003f);
      apb(1'b1, ADR_IRQ_EN, 32'h0000_0001);
      contact_in <= 16'ha585;
      wt(100);
      contact_in <= 16'ha5a5;
      n = 0;
      while (irq !== 1'b1 && n < 300)
      begin
         wt(1);
         n++;
      end
      chk({31'h0, irq}, 32'h1);
      rdchk(ADR_EVENT, 32'h8000_0005);
      apb(1'b0, ADR_STAMP, 32'h0);
      s1 = rd;
      wt(50);
      rdchk(ADR_EVENT, 32'h8000_0015);
      apb(1'b0, ADR_STAMP, 32'h0);
      chk(rd - s1, 32'h0000_0005);
      apb(1'b0, ADR_EVENT, 32'h0);
      chk({31'h0, rd[EVT_VALID_BIT]}, 32'h0);
      primary_link_up <= 1'b0;
      wt(10);
      chk({31'h0, net_port_sel}, 32'h1);
      rdchk(ADR_IDENT, 32'h0004_3c5a);
      apb(1'b0, 8'h4c, 32'h0);
      chk({err, rd[30:0]}, 32'h8000_0000);
      // ch0 filtered for 10 ticks: a change shows only after it
      apb(1'b1, ADR_FILTER0, 32'h0000_0001);
      contact_in[0] <= 1'b0;
      wt(100);
      chk({31'h0, led_green[0]}, 32'h0);
      wt(200);
      chk({31'h0, led_green[0]}, 32'h1);
      wet_board_type <= 2'h3;
      apb(1'b1, ADR_ISOLATE, 32'h0000_ffff);
      rdchk(ADR_ISOLATE, 32'h0000_0000);
      // back on an isolating board the refused write must not show
      wet_board_type <= 2'h1;
      wt(3);
      rdchk(ADR_ISOLATE, 32'h0000_0000);
      apb(1'b1, ADR_CTRL, 32'h0000_000d);
      rdchk(ADR_CTRL, 32'h0000_000d);
      apb(1'b1, ADR_CTRL, 32'h0000_000e);
      rdchk(ADR_CTRL, 32'h0000_000d);
      wrap_up();
   end
endmodule
